// *** inc/i2c_pkg.sv ***
// shared constants for the i2c target port and its bus controller
`default_nettype none
package i2c_pkg;
  // target address layout
  localparam logic [1:0] addr_fixed_top = 2'h1;
  localparam logic [1:0] addr_first_port_straps = 2'h3;
  localparam int port_first = 1;
  localparam int port_second = 2;
  localparam logic [2:0] code_primary = 3'h0;
  localparam logic [2:0] code_secondary = 3'h7;
  localparam int byte_bits = 8;
  localparam logic [3:0] ack_bit_index = 4'h8;

  // timing at 200 mhz
  localparam int clk_period_ps = 5000;
  localparam int t_high_min_ns = 4000;
  localparam int t_low_min_ns = 4700;
  localparam int high_min_cycles = (t_high_min_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int low_min_cycles = (t_low_min_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int boot_cycles = 16;

  // controller registers on apb
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_target = 8'h04;
  localparam logic [7:0] reg_sub = 8'h08;
  localparam logic [7:0] reg_wdata = 8'h0c;
  localparam logic [7:0] reg_rdata = 8'h10;
  localparam logic [7:0] reg_status = 8'h14;
  localparam int ctrl_go_bit = 0;
  localparam int ctrl_read_bit = 1;
  localparam int status_busy_bit = 0;
  localparam int status_done_bit = 1;
  localparam int status_nack_bit = 2;
  localparam logic [6:0] target_reset = 7'h00;

  function automatic logic [6:0] compose_addr(input int port, input logic strap_b, input logic strap_a,
                                              input logic [2:0] code);
    logic [1:0] straps;
    straps = (port == port_first) ? addr_first_port_straps : {strap_b, strap_a};
    compose_addr = {addr_fixed_top, straps, code};
  endfunction : compose_addr
endpackage : i2c_pkg
`default_nettype wire

// *** inc/i2c_link_if.sv ***
// open-drain i2c link joining target and controller
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_oe_t;
  logic sda_oe_t;
  logic scl_out_t;
  logic sda_out_t;
  logic scl_oe_c;
  logic sda_oe_c;
  logic scl_out_c;
  logic sda_out_c;
  logic scl;
  logic sda;

  // wired-and with pullups
  assign scl = !((scl_oe_t && !scl_out_t) || (scl_oe_c && !scl_out_c));
  assign sda = !((sda_oe_t && !sda_out_t) || (sda_oe_c && !sda_out_c));

  modport target (input scl, input sda, output scl_oe_t, output sda_oe_t, output scl_out_t, output sda_out_t);
  modport ctrl (input scl, input sda, output scl_oe_c, output sda_oe_c, output scl_out_c, output sda_out_c);
endinterface : i2c_link_if
`default_nettype wire

// *** design/i2c_target.sv ***
// i2c target port with clock stretching and strap-formed address
`timescale 1ns/1ps
`default_nettype none
module i2c_target
  import i2c_pkg::*;
#(
  parameter int port_number = i2c_pkg::port_first
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  i2c_link_if.target link,
  input wire logic addr_strap_bit_a,
  input wire logic addr_strap_bit_b,
  input wire logic [2:0] addr_code,
  output logic port_ready,
  output logic [6:0] own_addr,
  output logic role_primary,
  output logic role_secondary,
  output logic cmd_valid,
  output logic cmd_sub,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  output logic rsp_req,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  import i2c_pkg::*;

  typedef enum logic [2:0] {st_idle, st_rx, st_rx_ack, st_hold_rx, st_tx, st_tx_ack, st_hold_tx} state_type;

  state_type state;
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic scl_d;
  logic sda_d;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic is_addr;
  logic first;
  logic rw;
  logic m_ack;
  logic [4:0] boot_cnt;
  logic scl_oe;
  logic sda_oe;

  wire scl_s = sync2[6];
  wire sda_s = sync2[5];
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

  assign link.scl_oe_t = scl_oe;
  assign link.sda_oe_t = sda_oe;
  assign link.scl_out_t = 1'b0;
  assign link.sda_out_t = 1'b0;

  // pins and the analog decode come from outside this clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 7'h7f;
      sync2 <= 7'h7f;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1 <= {link.scl, link.sda, addr_strap_bit_b, addr_strap_bit_a, addr_code};
      sync2 <= sync1;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // boot: let the synchronisers settle, then latch the address once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_cnt <= 5'h00;
      port_ready <= 1'b0;
      own_addr <= 7'h00;
      role_primary <= 1'b0;
      role_secondary <= 1'b0;
    end
    else if (clk_en && !port_ready)
    begin
      if (boot_cnt == 5'(boot_cycles))
      begin
        own_addr <= compose_addr(port_number, sync2[4], sync2[3], sync2[2:0]);
        role_primary <= (sync2[2:0] == code_primary);
        role_secondary <= (sync2[2:0] == code_secondary);
        port_ready <= 1'b1;
      end
      else
        boot_cnt <= boot_cnt + 5'h01;
    end
  end

  // byte engine; own sda changes happen only while scl is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= st_idle;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      is_addr <= 1'b0;
      first <= 1'b0;
      rw <= 1'b0;
      m_ack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_sub <= 1'b0;
      cmd_data <= 8'h00;
      rsp_req <= 1'b0;
    end
    else if (clk_en)
    begin
      if (stop_cond || (start_cond && !port_ready))
      begin
        state <= st_idle;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        cmd_valid <= 1'b0;
        rsp_req <= 1'b0;
      end
      else if (start_cond)
      begin
        // repeated start also lands here
        state <= st_rx;
        bitcnt <= 4'h0;
        is_addr <= 1'b1;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (state)
          st_idle:
          begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
          st_rx:
          begin
            if (scl_rise && bitcnt < ack_bit_index)
            begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == ack_bit_index)
            begin
              if (is_addr)
              begin
                if (shreg[7:1] == own_addr)
                begin
                  sda_oe <= 1'b1;
                  rw <= shreg[0];
                  first <= !shreg[0];
                  state <= st_rx_ack;
                end
                else
                  state <= st_idle;
              end
              else
              begin
                // hold the bus until the core takes the byte
                scl_oe <= 1'b1;
                sda_oe <= 1'b1;
                cmd_valid <= 1'b1;
                cmd_sub <= first;
                cmd_data <= shreg;
                state <= st_hold_rx;
              end
            end
          end
          st_hold_rx:
          begin
            if (cmd_ready)
            begin
              cmd_valid <= 1'b0;
              first <= 1'b0;
              scl_oe <= 1'b0;
              state <= st_rx_ack;
            end
          end
          st_rx_ack:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              is_addr <= 1'b0;
              bitcnt <= 4'h0;
              if (rw)
              begin
                scl_oe <= 1'b1;
                rsp_req <= 1'b1;
                state <= st_hold_tx;
              end
              else
                state <= st_rx;
            end
          end
          st_hold_tx:
          begin
            if (rsp_valid)
            begin
              shreg <= rsp_data;
              sda_oe <= !rsp_data[7];
              bitcnt <= 4'h1;
              rsp_req <= 1'b0;
              scl_oe <= 1'b0;
              state <= st_tx;
            end
          end
          st_tx:
          begin
            if (scl_fall)
            begin
              if (bitcnt == ack_bit_index)
              begin
                sda_oe <= 1'b0;
                state <= st_tx_ack;
              end
              else
              begin
                sda_oe <= !shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          st_tx_ack:
          begin
            if (scl_rise)
              m_ack <= !sda_s;
            else if (scl_fall)
            begin
              if (m_ack)
              begin
                scl_oe <= 1'b1;
                rsp_req <= 1'b1;
                state <= st_hold_tx;
              end
              else
                state <= st_idle;
            end
          end
        endcase
      end
    end
  end
endmodule : i2c_target
`default_nettype wire

// *** design/i2c_controller.sv ***
// i2c bus controller driven over apb, one sub-addressed byte per order
`timescale 1ns/1ps
`default_nettype none
module i2c_controller
  import i2c_pkg::*;
#(
  parameter int high_cycles = i2c_pkg::high_min_cycles,
  parameter int low_cycles = i2c_pkg::low_min_cycles
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  i2c_link_if.ctrl link
);
  import i2c_pkg::*;

  typedef enum logic [2:0] {c_idle, c_start, c_low, c_wait_high, c_high, c_rs_low, c_rs_wait, c_stop_low} cstate_type;
  typedef enum logic [1:0] {nx_bit, nx_rstart, nx_stop} next_type;

  cstate_type state;
  next_type after_high;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [9:0] cnt;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [2:0] byte_sel;
  logic rd_mode;
  logic [6:0] target;
  logic [7:0] sub;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy;
  logic done;
  logic nack;
  logic scl_oe;
  logic sda_oe;
  logic go;

  wire scl_s = sync2[1];
  wire sda_s = sync2[0];
  wire access = psel && penable && pready;
  wire rx_byte = (byte_sel == 3'h4);

  assign link.scl_oe_c = scl_oe;
  assign link.sda_oe_c = sda_oe;
  assign link.scl_out_c = 1'b0;
  assign link.sda_out_c = 1'b0;

  function automatic logic [7:0] byte_for(input logic [2:0] sel, input logic [6:0] t, input logic [7:0] s,
                                          input logic [7:0] w);
    unique case (sel)
      3'h0: byte_for = {t, 1'b0};
      3'h1: byte_for = s;
      3'h2: byte_for = w;
      3'h3: byte_for = {t, 1'b1};
      default: byte_for = 8'hff;
    endcase
  endfunction : byte_for

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == reg_ctrl) || (a == reg_target) || (a == reg_sub) || (a == reg_wdata) ||
             (a == reg_rdata) || (a == reg_status);
  endfunction : mapped

  // apb: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (clk_en)
    begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          reg_ctrl: prdata <= {31'h0, rd_mode} << ctrl_read_bit;
          reg_target: prdata <= {25'h0, target};
          reg_sub: prdata <= {24'h0, sub};
          reg_wdata: prdata <= {24'h0, wdata};
          reg_rdata: prdata <= {24'h0, rdata};
          reg_status: prdata <= {29'h0, nack, done, busy};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // orders are ignored while a transfer runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target <= target_reset;
      sub <= 8'h00;
      wdata <= 8'h00;
      rd_mode <= 1'b0;
      go <= 1'b0;
    end
    else if (clk_en)
    begin
      go <= 1'b0;
      if (access && pwrite && !busy)
      begin
        unique case (paddr)
          reg_ctrl:
          begin
            rd_mode <= pwdata[ctrl_read_bit];
            go <= pwdata[ctrl_go_bit];
          end
          reg_target: target <= pwdata[6:0];
          reg_sub: sub <= pwdata[7:0];
          reg_wdata: wdata <= pwdata[7:0];
          default: go <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end
    else if (clk_en)
    begin
      sync1 <= {link.scl, link.sda};
      sync2 <= sync1;
    end
  end

  // scl comes from a divider of pclk; high time counts only from seen high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= c_idle;
      after_high <= nx_bit;
      cnt <= 10'h0;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      byte_sel <= 3'h0;
      rdata <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt <= cnt + 10'h1;
      unique case (state)
        c_idle:
        begin
          if (go)
          begin
            busy <= 1'b1;
            done <= 1'b0;
            nack <= 1'b0;
            byte_sel <= 3'h0;
            sda_oe <= 1'b1;
            cnt <= 10'h0;
            state <= c_start;
          end
        end
        c_start:
        begin
          if (cnt == 10'(high_cycles))
          begin
            scl_oe <= 1'b1;
            shreg <= byte_for(byte_sel, target, sub, wdata);
            bitcnt <= 4'h0;
            cnt <= 10'h0;
            state <= c_low;
          end
        end
        c_low:
        begin
          if (cnt == 10'h0)
          begin
            sda_oe <= (bitcnt < ack_bit_index) && !rx_byte && !shreg[7];
          end
          if (cnt == 10'(low_cycles))
          begin
            scl_oe <= 1'b0;
            state <= c_wait_high;
          end
        end
        c_wait_high:
        begin
          cnt <= 10'h0;
          if (scl_s)
          begin
            state <= c_high;
          end
        end
        c_high:
        begin
          if (cnt == 10'(high_cycles))
          begin
            scl_oe <= 1'b1;
            cnt <= 10'h0;
            if (bitcnt < ack_bit_index)
            begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
              state <= c_low;
            end
            else if (rx_byte)
            begin
              rdata <= shreg;
              state <= c_stop_low;
            end
            else if (sda_s)
            begin
              nack <= 1'b1;
              state <= c_stop_low;
            end
            else if (byte_sel == 3'h1 && rd_mode)
            begin
              state <= c_rs_low;
            end
            else if (byte_sel == 3'h2)
            begin
              state <= c_stop_low;
            end
            else
            begin
              byte_sel <= byte_sel + 3'h1;
              shreg <= byte_for(byte_sel + 3'h1, target, sub, wdata);
              bitcnt <= 4'h0;
              state <= c_low;
            end
          end
        end
        c_rs_low:
        begin
          sda_oe <= 1'b0;
          after_high <= nx_rstart;
          if (cnt == 10'(low_cycles))
          begin
            scl_oe <= 1'b0;
            state <= c_rs_wait;
          end
        end
        c_stop_low:
        begin
          sda_oe <= 1'b1;
          after_high <= nx_stop;
          if (cnt == 10'(low_cycles))
          begin
            scl_oe <= 1'b0;
            state <= c_rs_wait;
          end
        end
        c_rs_wait:
        begin
          if (!scl_s)
          begin
            cnt <= 10'h0;
          end
          else if (cnt == 10'(high_cycles))
          begin
            cnt <= 10'h0;
            if (after_high == nx_rstart)
            begin
              sda_oe <= 1'b1;
              byte_sel <= 3'h3;
              state <= c_start;
            end
            else
            begin
              sda_oe <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              state <= c_idle;
            end
          end
        end
      endcase
    end
  end
endmodule : i2c_controller
`default_nettype wire

// *** verification/i2c_link_properties.sv ***
// assertions on the i2c link and the target port beside it
`timescale 1ns/1ps
`default_nettype none
module i2c_link_properties
#(
  parameter int high_cycles = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic scl_oe_t,
  input wire logic sda_oe_t,
  input wire logic scl_oe_c,
  input wire logic port_ready,
  input wire logic [6:0] own_addr,
  input wire logic role_primary,
  input wire logic role_secondary,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int high_count;
  // a counter, since the high time is far beyond a repetition
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      high_count <= 0;
    else if (scl)
      high_count <= high_count + 1;
    else
      high_count <= 0;
  sequence s_byte_pending;
    cmd_valid && !cmd_ready;
  endsequence
  sequence s_target_stretching;
    scl_oe_t && !scl_oe_c;
  endsequence
  AST_SILENT_BEFORE_READY: assert property (!port_ready |-> !scl_oe_t && !sda_oe_t)
    else $error("target drove the link before its address was set");
  AST_ADDR_HELD: assert property (port_ready && $past(port_ready) |-> $stable(own_addr))
    else $error("address moved after boot");
  AST_ADDR_FIXED_TOP: assert property (port_ready |-> own_addr[6:3] == 4'h7)
    else $error("first port address top bits wrong");
  AST_ROLE_FROM_CODE: assert property (port_ready |-> role_primary == (own_addr[2:0] == 3'h0)
    && role_secondary == (own_addr[2:0] == 3'h7)) else $error("role does not follow code");
  AST_STRETCH_ON_BYTE: assert property (s_byte_pending ##1 s_byte_pending |-> scl_oe_t)
    else $error("scl released while a byte is unhandled");
  AST_STRETCH_ON_RSP: assert property (rsp_req && $past(rsp_req) |-> scl_oe_t)
    else $error("scl released while no reply byte is ready");
  AST_STRETCH_FROM_LOW: assert property ($rose(scl_oe_t) |-> !$past(scl))
    else $error("stretch began during a high clock");
  AST_CTRL_WAITS: assert property (s_target_stretching ##1 scl_oe_t |-> !scl_oe_c)
    else $error("controller pulled scl during a stretch");
  AST_SCL_HIGH_MIN: assert property ($fell(scl) |-> high_count >= high_cycles)
    else $error("scl high time too short");
  AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(sda_oe_t))
    else $error("target changed sda while scl high");
  AST_SDA_MOVES_LOW: assert property ($changed(sda_oe_t) |-> !$past(scl))
    else $error("target sda change not in low phase");
endmodule : i2c_link_properties
`default_nettype wire

// *** verification/i2c_target_stretch_addr_strap_tb.sv ***
// bench: controller and first target on one link, second target for straps
`timescale 1ns/1ps
`default_nettype none
module i2c_target_stretch_addr_strap_tb;
  import i2c_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, port_ready, port_ready_2, role_primary, role_secondary, role_primary_2;
  logic addr_strap_bit_a = 1'b0;
  logic addr_strap_bit_b = 1'b0;
  logic [2:0] code_1 = 3'h0;
  logic [2:0] code_2 = 3'h0;
  logic [6:0] own_addr, own_addr_2;
  logic cmd_valid, cmd_sub, rsp_req;
  logic [7:0] cmd_data;
  logic cmd_ready = 1'b0;
  logic rsp_valid = 1'b0;
  logic [7:0] rsp_data = 8'h00;
  logic [7:0] rsp_byte = 8'h00;
  logic [8:0] cmd_log[$];
  int stall = 0;
  int wait_cnt = 0;
  int fail_count = 0;
  int compares = 0;
  i2c_link_if la();
  i2c_link_if lb();
  // second link has no controller: lines idle high
  assign lb.scl_oe_c = 1'b0;
  assign lb.sda_oe_c = 1'b0;
  assign lb.scl_out_c = 1'b0;
  assign lb.sda_out_c = 1'b0;
  i2c_controller #(.high_cycles(8), .low_cycles(10)) u_i2c_controller (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(la));
  i2c_target #(.port_number(1)) u_i2c_target (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .link(la),
    .addr_strap_bit_a(addr_strap_bit_a), .addr_strap_bit_b(addr_strap_bit_b), .addr_code(code_1),
    .port_ready(port_ready), .own_addr(own_addr), .role_primary(role_primary), .role_secondary(role_secondary),
    .cmd_valid(cmd_valid), .cmd_sub(cmd_sub), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_req(rsp_req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  i2c_target #(.port_number(2)) u_i2c_target_2 (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .link(lb),
    .addr_strap_bit_a(addr_strap_bit_a), .addr_strap_bit_b(addr_strap_bit_b), .addr_code(code_2),
    .port_ready(port_ready_2), .own_addr(own_addr_2), .role_primary(role_primary_2), .role_secondary(),
    .cmd_valid(), .cmd_sub(), .cmd_data(), .cmd_ready(cmd_ready), .rsp_req(), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  i2c_link_properties #(.high_cycles(8)) u_i2c_link_properties (.pclk(pclk), .presetn(presetn), .scl(la.scl),
    .scl_oe_t(la.scl_oe_t), .sda_oe_t(la.sda_oe_t), .scl_oe_c(la.scl_oe_c), .port_ready(port_ready),
    .own_addr(own_addr), .role_primary(role_primary), .role_secondary(role_secondary), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_req(rsp_req));
  initial
    forever #2.5 pclk = ~pclk;
  // core side: answers late on purpose so the target has to stretch
  always @(posedge pclk)
  begin
    cmd_ready <= 1'b0;
    rsp_valid <= 1'b0;
    wait_cnt <= ((cmd_valid && !cmd_ready) || (rsp_req && !rsp_valid)) ? wait_cnt + 1 : 0;
    if (cmd_valid && !cmd_ready && wait_cnt >= stall)
    begin
      cmd_ready <= 1'b1;
      cmd_log.push_back({cmd_sub, cmd_data});
    end
    if (rsp_req && !rsp_valid && wait_cnt >= stall)
    begin
      rsp_valid <= 1'b1;
      rsp_data <= rsp_byte;
    end
  end
  function automatic logic [6:0] want_addr(input logic two, input logic b, input logic a, input logic [2:0] c);
    want_addr = {2'h1, (two ? {b, a} : 2'h3), c};
  endfunction : want_addr
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_flag(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask : check_flag
  task automatic give_up();
    check_flag(1'b0, 1'b1);
    print_verdict();
  endtask : give_up
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      give_up();
  endtask : apb
  task automatic do_reset();
    int n;
    n = 0;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    while (!(port_ready === 1'b1 && port_ready_2 === 1'b1) && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
      give_up();
  endtask : do_reset
  // one sub-addressed transfer through the controller registers
  task automatic run(input logic rd, input logic [6:0] tgt, input logic ack);
    logic [31:0] st, d;
    logic e;
    logic [7:0] sub, wd;
    int n;
    sub = 8'($urandom);
    wd = 8'($urandom);
    rsp_byte = 8'($urandom);
    stall = $urandom % 31;
    cmd_log.delete();
    n = 0;
    apb(1'b1, reg_target, 32'(tgt), d, e);
    apb(1'b1, reg_sub, 32'(sub), d, e);
    apb(1'b1, reg_wdata, 32'(wd), d, e);
    apb(1'b1, reg_ctrl, {30'h0, rd, 1'b1}, d, e);
    repeat (4) @(posedge pclk);
    do
    begin
      apb(1'b0, reg_status, 32'h0, st, e);
      n++;
    end
    while (st[status_busy_bit] !== 1'b0 && n < 4000);
    if (n >= 4000)
      give_up();
    check_flag(st[status_done_bit], 1'b1);
    check_flag(st[status_nack_bit], !ack);
    check_val(32'(cmd_log.size()), !ack ? 0 : (rd ? 1 : 2));
    if (ack)
      check_val(32'(cmd_log[0]), {23'h0, 1'b1, sub});
    if (ack && !rd)
      check_val(32'(cmd_log[1]), {24'h0, wd});
    apb(1'b0, reg_rdata, 32'h0, d, e);
    if (ack && rd)
      check_val(d, {24'h0, rsp_byte});
    $display("transfer read %0b ack %0b stall %0d done", rd, ack, stall);
  endtask : run
  initial
  begin
    logic [31:0] d;
    logic e;
    int i;
    d = $urandom(32'hd48e913c);
    for (i = 0; i < 8; i++)
    begin
      d = $urandom;
      @(posedge pclk);
      code_1 <= 3'(i);
      code_2 <= 3'(7 - i);
      {addr_strap_bit_b, addr_strap_bit_a} <= d[1:0];
      do_reset();
      check_val(32'(own_addr), 32'(want_addr(1'b0, d[1], d[0], 3'(i))));
      check_val(32'(own_addr_2), 32'(want_addr(1'b1, d[1], d[0], 3'(7 - i))));
      check_flag(role_primary, i == 0);
      check_flag(role_secondary, i == 7);
      check_flag(role_primary_2, i == 7);
      $display("address code %0d done", i);
    end
    apb(1'b1, reg_sub, 32'h5a, d, e);
    apb(1'b0, reg_sub, 32'h0, d, e);
    check_val(d, 32'h5a);
    check_flag(e, 1'b0);
    apb(1'b0, 8'h40, 32'h0, d, e);
    check_flag(e, 1'b1);
    check_val(d, 32'h0);
    $display("register access done");
    for (i = 0; i < 6; i++)
      run(i[0], own_addr, 1'b1);
    run(1'b0, own_addr ^ 7'h08, 1'b0);
    run(1'b1, own_addr ^ 7'h01, 1'b0);
    print_verdict();
  end
endmodule : i2c_target_stretch_addr_strap_tb
`default_nettype wire
